//--- hw/sfp_flash_if.sv
// serial flash pin interface: write-data fifo and the device-side pin engine
// How it works
// (RULE1) select high deselects; device falls to standby, never deep power-down
// (RULE2) output lines are released while deselected
// (RULE3) input line is ignored while deselected
// (RULE4) a frame starts on select falling and ends on select rising
// (RULE5) a timed program or erase keeps the device busy past frame end
// (RULE6) command, address and write data are taken on clock rising edges
// (RULE7) read data changes on clock falling edges
// (RULE8) dual read drives both data lines, two bits per falling edge
// (RULE9) dual program samples both data lines, two bits per rising edge
// (RULE10) pause blocks clock and input, and releases outputs
// (RULE11) host starts a pause only while selected with clock low
// (RULE12) pause leaves a running program or erase untouched
// (RULE13) pause neither deselects nor resets; the transfer resumes
// (RULE14) protect input low blocks every change of sector protection
// (RULE15) protect and pause inputs idle high when left open
// (RULE16) each sector has its own protect bit blocking program and erase
// (RULE17) global commands protect or unprotect all sectors at once
// (RULE18) any 64 KiB sector can be locked read-only for good; here reset clears the locks
// (RULE19) the security register programs once, then never changes; here reset clears otp_done and reopens it
// (RULE20) erase works on 4 KiB units
// (RULE21) host releases the input line during a dual read
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sfp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sfp_flash_if
    import sfp_pkg::*;
#(
    parameter int BUSY_LEN = sfp_pkg::BUSY_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic data_line0_bidir_in,
    output logic data_line0_bidir_out,
    output logic data_line0_bidir_oe,
    input wire logic data_line1_bidir_in,
    output logic data_line1_bidir_out,
    output logic data_line1_bidir_oe,
    output logic [sfp_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic [7:0] wr_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic op_valid,
    output sfp_pkg::sfp_opk_t op_kind,
    output logic [sfp_pkg::ADDR_W-1:0] op_addr,
    output logic busy,
    output logic standby,
    output logic overrun,
    output logic [sfp_pkg::SECTORS-1:0] sector_prot,
    output logic [sfp_pkg::SECTORS-1:0] sector_lock
);
    import sfp_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [PIN_N-1:0] meta;
    logic [PIN_N-1:0] pin;
    logic [PIN_N-1:0] prev;
    sfp_state_t state;
    logic [7:0] shin;
    logic [2:0] bitcnt;
    logic [1:0] abytes;
    logic [7:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] shout;
    logic [2:0] obit;
    logic rd_drive;
    logic wrote;
    logic otp_done;
    logic [7:0] otp_mem [OTP_BYTES];
    logic [$clog2(BUSY_LEN+1)-1:0] busy_cnt;
    logic fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // every pin crosses two flops; idle-high reset stands in for the pull-ups
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta <= PIN_IDLE; // see (RULE15)
            pin <= PIN_IDLE;
            prev <= PIN_IDLE;
        end
        else
        begin
            meta <= {data_line1_bidir_in, data_line0_bidir_in, wp_n, hold_n, sck, cs_n};
            pin <= meta;
            prev <= pin;
        end
    end

    logic cs_act;
    logic hold;
    logic wp_ok;
    logic din0;
    logic din1;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    assign cs_act = !pin[PIN_CS];
    assign hold = !pin[PIN_HOLD];
    assign wp_ok = pin[PIN_WP];
    assign din0 = pin[PIN_DL0];
    assign din1 = pin[PIN_DL1];
    assign cs_fall = prev[PIN_CS] && !pin[PIN_CS]; // see (RULE4)
    assign cs_rise = !prev[PIN_CS] && pin[PIN_CS];
    // edges count only while selected and not paused
    assign sck_rise = pin[PIN_SCK] && !prev[PIN_SCK] && cs_act && !hold; // see (RULE3) (RULE10)
    assign sck_fall = !pin[PIN_SCK] && prev[PIN_SCK] && cs_act && !hold;

    ////////////////////////////////////////////////////////////////////////////
    logic in_dual;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [SEC_W-1:0] sec;
    logic sec_blocked;
    logic is_prog;
    logic is_otp_prog;
    logic fifo_push;
    logic otp_we;
    logic frame_ok;
    logic ld_byte;
    assign in_dual = (state == ST_PROG) && (cmd == OP_DUAL_PROG);
    assign rx_byte = in_dual ? {shin[5:0], din1, din0} : {shin[6:0], din0}; // see (RULE9)
    assign byte_done = sck_rise && (bitcnt == (in_dual ? 3'(BIT_LAST_DUAL) : 3'(BIT_LAST_SINGLE)));
    assign sec = addr[SEC_LSB +: SEC_W];
    assign sec_blocked = sector_prot[sec] || sector_lock[sec]; // see (RULE16) (RULE18)
    assign is_prog = (cmd == OP_PROG) || (cmd == OP_DUAL_PROG);
    assign is_otp_prog = (cmd == OP_OTP_PROG);
    // a full fifo aborts the program: the byte is refused and the commit dropped
    assign fifo_push = byte_done && (state == ST_PROG) && is_prog && !sec_blocked && !overrun;
    assign otp_we = byte_done && (state == ST_PROG) && is_otp_prog && !otp_done; // see (RULE19)
    assign frame_ok = ((state == ST_TAIL) || (state == ST_PROG)) && (bitcnt == '0);
    assign ld_byte = sck_fall && (state == ST_READ) && (obit == '0);

    // frame sequencing; a pause freezes it because the edges vanish
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            shin <= '0;
            bitcnt <= '0;
            abytes <= '0;
            cmd <= '0;
            addr <= '0;
        end
        else if (cs_fall)
        begin
            state <= busy ? ST_IGNORE : ST_CMD; // see (RULE4) (RULE13)
            bitcnt <= '0;
            abytes <= '0;
        end
        else if (!cs_act)
        begin
            state <= ST_IDLE; // see (RULE1)
        end
        else if (sck_rise)
        begin
            shin <= rx_byte; // see (RULE6)
            bitcnt <= byte_done ? '0 : bitcnt + 1'b1;
            if (byte_done)
            begin
                unique case (state)
                    ST_CMD:
                    begin
                        cmd <= rx_byte;
                        if (rx_byte == OP_GLOB_PROT || rx_byte == OP_GLOB_UNPROT)
                        begin
                            state <= ST_TAIL;
                        end
                        else
                        begin
                            state <= ST_ADDR;
                        end
                    end
                    ST_ADDR:
                    begin
                        addr <= {addr[ADDR_W-9:0], rx_byte};
                        abytes <= abytes + 1'b1;
                        if (abytes == 2'(ADDR_BYTES_LAST))
                        begin
                            if (cmd == OP_READ || cmd == OP_DUAL_READ || cmd == OP_OTP_READ)
                            begin
                                state <= ST_READ;
                            end
                            else if (is_prog || is_otp_prog)
                            begin
                                state <= ST_PROG;
                            end
                            else
                            begin
                                state <= ST_TAIL;
                            end
                        end
                    end
                    // page wrap keeps the running address in its sector
                    ST_PROG: addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1;
                    ST_IDLE, ST_READ, ST_TAIL, ST_IGNORE:
                    begin
                    end
                endcase
            end
        end
        else if (ld_byte)
        begin
            addr <= addr + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read shifter; data moves only on falling edges
    logic dual_rd;
    logic [7:0] src;
    logic [7:0] obyte;
    assign dual_rd = (cmd == OP_DUAL_READ);
    assign src = (cmd == OP_OTP_READ) ? otp_mem[addr[OTP_AW-1:0]] : rd_data;
    assign obyte = (obit == '0) ? src : shout;
    assign rd_addr = addr;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            shout <= '0;
            obit <= '0;
            rd_drive <= 1'b0;
            data_line0_bidir_out <= 1'b0;
            data_line1_bidir_out <= 1'b0;
        end
        else if (cs_fall)
        begin
            obit <= '0;
            rd_drive <= 1'b0;
        end
        else if (sck_fall && state == ST_READ)
        begin
            rd_drive <= 1'b1;
            data_line1_bidir_out <= obyte[7]; // see (RULE7)
            if (dual_rd)
            begin
                data_line0_bidir_out <= obyte[6]; // see (RULE8)
                shout <= {obyte[5:0], 2'b00};
                obit <= (obit == 3'(BIT_LAST_DUAL)) ? '0 : obit + 1'b1;
            end
            else
            begin
                shout <= {obyte[6:0], 1'b0};
                obit <= obit + 1'b1;
            end
        end
    end

    // drivers drop one clock after the synchronised deselect or pause
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            data_line0_bidir_oe <= 1'b0;
            data_line1_bidir_oe <= 1'b0;
        end
        else
        begin
            // tied to the read state so a stale drive flag cannot leak into the next frame
            data_line1_bidir_oe <= cs_act && !hold && (state == ST_READ) &&
                (rd_drive || sck_fall); // see (RULE2) (RULE10)
            data_line0_bidir_oe <= cs_act && !hold && dual_rd && (state == ST_READ) &&
                (rd_drive || sck_fall); // see (RULE8) (RULE21)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sfp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(rx_byte),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(wr_data),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );

    // overrun is raised by a refused byte, cleared by the next frame start
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            overrun <= 1'b0;
            wrote <= 1'b0;
        end
        else
        begin
            if (fifo_push && !fifo_in_ready)
            begin
                overrun <= 1'b1;
            end
            else if (cs_fall)
            begin
                overrun <= 1'b0;
            end
            if (fifo_push || otp_we)
            begin
                wrote <= 1'b1;
            end
            else if (cs_fall)
            begin
                wrote <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // commit at frame end; operations start only on a whole-byte frame
    logic commit;
    assign commit = cs_rise && frame_ok;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            op_valid <= 1'b0;
            op_kind <= OPK_PROGRAM;
            op_addr <= '0;
        end
        else
        begin
            op_valid <= 1'b0;
            if (commit && cmd == OP_ERASE && !sec_blocked)
            begin
                op_valid <= 1'b1;
                op_kind <= OPK_ERASE;
                op_addr <= {addr[ADDR_W-1:ERASE_LSB], ERASE_LSB'(0)}; // see (RULE20)
            end
            else if (commit && is_prog && wrote && !overrun)
            begin
                op_valid <= 1'b1;
                op_kind <= OPK_PROGRAM;
                op_addr <= {addr[ADDR_W-1:PAGE_W], PAGE_W'(0)};
            end
            else if (commit && is_otp_prog && wrote)
            begin
                op_valid <= 1'b1;
                op_kind <= OPK_OTP;
                op_addr <= '0;
            end
        end
    end

    // busy counts down regardless of pause
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy_cnt <= '0;
        end
        else if (op_valid)
        begin
            busy_cnt <= ($bits(busy_cnt))'(BUSY_LEN); // see (RULE5)
        end
        else if (busy_cnt != '0)
        begin
            busy_cnt <= busy_cnt - 1'b1; // see (RULE12)
        end
    end
    assign busy = (busy_cnt != '0) || op_valid;
    assign standby = !cs_act && !busy; // see (RULE1) (RULE5)

    ////////////////////////////////////////////////////////////////////////////
    // protection; lock bits are volatile here, reset is the only way back
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sector_prot <= '0;
            sector_lock <= '0;
        end
        else if (commit && wp_ok)
        begin
            unique case (cmd)
                OP_PROT: sector_prot[sec] <= 1'b1; // see (RULE14) (RULE16)
                OP_UNPROT: sector_prot[sec] <= 1'b0;
                OP_GLOB_PROT: sector_prot <= '1; // see (RULE17)
                OP_GLOB_UNPROT: sector_prot <= '0;
                OP_LOCK: sector_lock[sec] <= 1'b1; // see (RULE18)
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (otp_we)
        begin
            otp_mem[addr[OTP_AW-1:0]] <= rx_byte;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            otp_done <= 1'b0;
        end
        else if (commit && is_otp_prog && wrote)
        begin
            otp_done <= 1'b1; // see (RULE19)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_frame_end;
        cs_rise && frame_ok;
    endsequence

    sequence s_busy_run;
        busy && !standby;
    endsequence

    a_deselect_float: assert property (!cs_act // see (RULE2)
        |=> !data_line1_bidir_oe && !data_line0_bidir_oe)
        else $error("output driven while deselected");
    a_hold_float: assert property (hold // see (RULE10)
        |=> !data_line1_bidir_oe && !data_line0_bidir_oe)
        else $error("output driven during pause");
    a_ignore_input: assert property (!cs_act |=> $stable(shin)) // see (RULE3)
        else $error("input shifted while deselected");
    a_frame_start: assert property (cs_fall && !busy |=> state == ST_CMD) // see (RULE4)
        else $error("frame did not start on select fall");
    a_busy_after: assert property (s_frame_end ##1 op_valid |-> s_busy_run [*3]) // see (RULE5)
        else $error("standby entered during timed operation");
    a_rise_sample: assert property (sck_rise && state == ST_CMD // see (RULE6)
        |=> shin[0] == $past(din0))
        else $error("bit not taken on rising edge");
    a_fall_update: assert property ($changed(data_line1_bidir_out) // see (RULE7)
        |-> $past(sck_fall))
        else $error("output changed off a falling edge");
    a_dual_drive: assert property (sck_fall && state == ST_READ && dual_rd
        |=> data_line0_bidir_oe && data_line1_bidir_oe) // see (RULE8)
        else $error("dual read not driving both lines");
    a_dual_sample: assert property (sck_rise && in_dual
        |=> shin[1:0] == {$past(din1), $past(din0)}) // see (RULE9)
        else $error("dual program sampled wrong bits");
    a_pause_busy: assert property (hold && busy_cnt > 1 && !op_valid
        |=> busy_cnt == $past(busy_cnt) - 1'b1) // see (RULE12)
        else $error("pause disturbed the busy timer");
    a_pause_keep: assert property ((hold && cs_act) ##1 cs_act // see (RULE13)
        |-> $stable(state) && $stable(bitcnt))
        else $error("pause changed the transfer state");
    a_wp_gate: assert property ($changed(sector_prot) || $changed(sector_lock) // see (RULE14)
        |-> $past(wp_ok))
        else $error("protection changed with protect input low");
    a_prot_block: assert property (fifo_push // see (RULE16)
        |-> !sector_prot[sec] && !sector_lock[sec])
        else $error("write accepted into protected sector");
    a_lock_kept: assert property (($past(sector_lock) & ~sector_lock) == '0) // see (RULE18)
        else $error("sector lock cleared");
    a_otp_once: assert property (otp_done |-> !otp_we) // see (RULE19)
        else $error("security register written twice");
    a_erase_align: assert property (op_valid && op_kind == OPK_ERASE
        |-> op_addr[ERASE_LSB-1:0] == '0) // see (RULE20)
        else $error("erase address not unit aligned");
endmodule

//--- hw/sfp_pkg.sv
// constants and types shared by the serial flash pin interface
package sfp_pkg;
    localparam int ADDR_W = 24;
    localparam int SECTORS = 16;
    localparam int SEC_LSB = 16;
    localparam int SEC_W = 4;
    localparam int ERASE_LSB = 12;
    localparam int PAGE_W = 8;
    localparam int OTP_BYTES = 8;
    localparam int OTP_AW = 3;
    localparam int BUSY_CYCLES = 64;
    localparam int FIFO_DEPTH = 8;
    localparam int ADDR_BYTES_LAST = 2;
    localparam int BIT_LAST_SINGLE = 7;
    localparam int BIT_LAST_DUAL = 3;

    // synchroniser lanes
    localparam int PIN_N = 6;
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_HOLD = 2;
    localparam int PIN_WP = 3;
    localparam int PIN_DL0 = 4;
    localparam int PIN_DL1 = 5;
    // idle level of every pin; the pause and protect pins float high
    localparam logic [PIN_N-1:0] PIN_IDLE = 6'h3f;

    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_DUAL_READ = 8'h3b;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_DUAL_PROG = 8'ha2;
    localparam logic [7:0] OP_ERASE = 8'h20;
    localparam logic [7:0] OP_PROT = 8'h36;
    localparam logic [7:0] OP_UNPROT = 8'h39;
    localparam logic [7:0] OP_GLOB_PROT = 8'h7e;
    localparam logic [7:0] OP_GLOB_UNPROT = 8'h98;
    localparam logic [7:0] OP_LOCK = 8'h33;
    localparam logic [7:0] OP_OTP_PROG = 8'h9b;
    localparam logic [7:0] OP_OTP_READ = 8'h77;

    typedef enum logic [1:0] {OPK_PROGRAM, OPK_ERASE, OPK_OTP} sfp_opk_t;
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_PROG, ST_READ, ST_TAIL, ST_IGNORE}
        sfp_state_t;
endpackage

//--- tb/sfp_flash_if_tb.sv
// self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
module sfp_flash_if_tb;
    import sfp_pkg::*;
    logic clk = 1'b0;
    logic rst_n;
    logic wp_n;
    logic wr_ready;
    logic ready_off = 1'b0;
    logic flip = 1'b0;
    logic op_seen = 1'b0;
    logic cs_n, sck, hold_n, h0, h0_oe, h1, h1_oe, line0, line1;
    logic o0, oe0, o1, oe1, wr_valid, op_valid, busy, standby, overrun;
    logic [23:0] rd_addr, op_addr;
    logic [7:0] wr_data, rd_data;
    logic [7:0] otp_exp [8];
    sfp_opk_t op_kind;
    logic [15:0] sector_prot, sector_lock;
    logic [7:0] exp_wr[$];
    logic [25:0] exp_op[$];
    integer seed = 32'h6ec7;
    int mismatches = 0;
    int n_compared = 0;
    function automatic logic [7:0] rd_fn(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction
    assign rd_data = rd_fn(rd_addr);
    always #4 clk = ~clk;
    always @(posedge clk)
        flip <= ~flip;
    // released lines wander so a stale value never passes
    assign line0 = oe0 ? o0 : (h0_oe ? h0 : flip);
    assign line1 = oe1 ? o1 : (h1_oe ? h1 : ~flip);
    sfp_host h (.clk(clk), .line0(line0), .line1(line1), .cs_n(cs_n), .sck(sck),
        .hold_n(hold_n), .d0(h0), .d0_oe(h0_oe), .d1(h1), .d1_oe(h1_oe));
    sfp_flash_if #(.BUSY_LEN(8)) dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
        .hold_n(hold_n), .wp_n(wp_n), .data_line0_bidir_in(line0),
        .data_line0_bidir_out(o0), .data_line0_bidir_oe(oe0), .data_line1_bidir_in(line1),
        .data_line1_bidir_out(o1), .data_line1_bidir_oe(oe1), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
        .busy(busy), .standby(standby), .overrun(overrun), .sector_prot(sector_prot),
        .sector_lock(sector_lock));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nb, input int m,
        input logic push, input logic hp);
        logic [7:0] rx, b;
        h.open_frame();
        h.xbyte(op, 0, rx);
        if (op != OP_GLOB_PROT && op != OP_GLOB_UNPROT)
            for (int i = 2; i >= 0; i--)
                h.xbyte(a[8*i +: 8], 0, rx);
        for (int k = 0; k < nb; k++)
        begin
            if (hp && k == 1)
                fork
                    h.pause(12);
                    begin
                        h.tick(8);
                        cmp({oe1, oe0}, 2'b00);
                    end
                join
            b = 8'($random(seed));
            // note first: the byte can leave the fifo before the slot ends
            if (push && op == OP_OTP_PROG)
                otp_exp[3'(a + 24'(k))] = b;
            else if (push && k < FIFO_DEPTH)
                exp_wr.push_back(b);
            h.xbyte(b, m, rx);
            if (op == OP_READ || op == OP_DUAL_READ)
                cmp(rx, rd_fn(a + 24'(k)));
            else if (op == OP_OTP_READ)
                cmp(rx, otp_exp[3'(a + 24'(k))]);
        end
        h.close_frame();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        op_seen <= op_valid;
        wr_ready <= ready_off ? 1'b0 : 1'($random(seed));
        if (op_seen === 1'b1)
            cmp({busy, standby}, 2'b10);
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            cmp(wr_data, exp_wr.size() > 0 ? exp_wr.pop_front() : 9'h100);
        if (op_valid === 1'b1)
            cmp({op_kind, op_addr},
                exp_op.size() > 0 ? exp_op.pop_front() : 27'h4000000);
    end
    initial
    begin
        h.tick(60000);
        mismatches++;
        test_done();
    end
    initial
    begin
        logic [1:0] r;
        rst_n <= 1'b0;
        wp_n <= 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        h.tick(4);
        cmp({standby, oe1, oe0}, 3'b100);
        frame(OP_READ, 24'h0123fe, 3, 0, 0, 1);
        frame(OP_DUAL_READ, 24'h0a00ff, 2, 2, 0, 0);
        exp_op.push_back({OPK_PROGRAM, 24'h023400});
        frame(OP_PROG, 24'h0234f0, 3, 0, 1, 0);
        exp_op.push_back({OPK_PROGRAM, 24'h056700});
        frame(OP_DUAL_PROG, 24'h056712, 2, 1, 1, 0);
        exp_op.push_back({OPK_ERASE, 24'h035000});
        frame(OP_ERASE, 24'h035678, 0, 0, 0, 0);
        frame(OP_PROT, 24'h030000, 0, 0, 0, 0);
        cmp(sector_prot, 16'h0008);
        frame(OP_ERASE, 24'h031000, 0, 0, 0, 0);
        frame(OP_UNPROT, 24'h030000, 0, 0, 0, 0);
        cmp(sector_prot, 16'h0000);
        frame(OP_GLOB_PROT, 24'h000000, 0, 0, 0, 0);
        cmp(sector_prot, 16'hffff);
        wp_n <= 1'b0;
        frame(OP_GLOB_UNPROT, 24'h000000, 0, 0, 0, 0);
        cmp(sector_prot, 16'hffff);
        wp_n <= 1'b1;
        frame(OP_GLOB_UNPROT, 24'h000000, 0, 0, 0, 0);
        cmp(sector_prot, 16'h0000);
        frame(OP_LOCK, 24'h050000, 0, 0, 0, 0);
        cmp(sector_lock, 16'h0020);
        frame(OP_ERASE, 24'h05f000, 0, 0, 0, 0);
        exp_op.push_back({OPK_OTP, 24'h000000});
        frame(OP_OTP_PROG, 24'h000000, 2, 0, 1, 0);
        frame(OP_OTP_PROG, 24'h000000, 2, 0, 0, 0);
        frame(OP_OTP_READ, 24'h000000, 2, 0, 0, 0);
        ready_off <= 1'b1;
        frame(OP_PROG, 24'h070010, 9, 0, 1, 0);
        cmp({overrun, wr_valid}, 2'b11);
        ready_off <= 1'b0;
        for (int i = 0; i < 400 && exp_wr.size() > 0; i++)
            h.tick(1);
        repeat (8) h.slot(2'b11, 1, r);
        h.close_frame();
        cmp({wr_valid, oe1, oe0}, 3'b000);
        cmp(exp_wr.size() + exp_op.size(), 0);
        test_done();
    end
endmodule

//--- tb/sfp_host.sv
// spi host model: select, clock, pause and both data lines
`timescale 1ns/1ps
module sfp_host (
    input wire logic clk,
    input wire logic line0,
    input wire logic line1,
    output logic cs_n,
    output logic sck,
    output logic hold_n,
    output logic d0,
    output logic d0_oe,
    output logic d1,
    output logic d1_oe
);
    initial
        {cs_n, sck, hold_n, d0, d0_oe, d1, d1_oe} = 7'h50;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // mode 0 single, 1 dual in, 2 dual out; five clocks each half period
    task automatic slot(input logic [1:0] tx, input int m, output logic [1:0] rx);
        d0_oe <= m != 2;
        d1_oe <= m == 1;
        d0 <= tx[0];
        d1 <= tx[1];
        tick(5);
        rx = {line1, line0};
        sck <= 1'b1;
        tick(5);
        sck <= 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] tx, input int m, output logic [7:0] rx);
        logic [1:0] r;
        for (int i = 7; i >= 0; i -= (m == 0 ? 1 : 2))
        begin
            slot(m == 0 ? {2{tx[i]}} : tx[i -: 2], m, r);
            if (m == 0)
                rx[i] = r[1];
            else
                rx[i -: 2] = r;
        end
    endtask
    task automatic open_frame;
        cs_n <= 1'b0;
        tick(5);
    endtask
    // long tail so a timed operation ends before the next frame
    task automatic close_frame;
        tick(5);
        {cs_n, d0_oe, d1_oe} <= 3'b100;
        tick(25);
    endtask
    // wait first: a pause seen with the last clock fall would swallow that edge
    task automatic pause(input int n);
        tick(3);
        hold_n <= 1'b0; // (only between slots: selected, clock low)
        tick(3);
        sck <= 1'b1;
        tick(3);
        sck <= 1'b0;
        tick(n);
        hold_n <= 1'b1;
        tick(3);
    endtask
endmodule
